// *** scwl_defs.svh ***
// Purpose: Constants for the synthesizer control word (low half) block
// Assumes: 20 MHz system clock, single clock domain
// Notes: Offsets, field positions and reset values used by the ramp, control and checker files
`ifndef SCWL_DEFS_SVH
`define SCWL_DEFS_SVH
// ==========================================================
// Register map
`define SCWL_ADDR_CTRL 8'h00
`define SCWL_ADDR_KMUL 8'h04
`define SCWL_ADDR_UPER 8'h08
`define SCWL_ADDR_STAT 8'h0C
// ==========================================================
// Control field positions
`define SCWL_B_ONESHOT 15
`define SCWL_B_ACCCLR 14
`define SCWL_B_TRI 13
`define SCWL_F_MODE 11:9
`define SCWL_B_INTUPD 8
`define SCWL_B_SINCBYP 6
`define SCWL_B_KEYEN 5
`define SCWL_B_KEYINT 4
`define SCWL_B_LSB 1
`define SCWL_B_SDO 0
`define SCWL_F_CTRL 14:0
`define SCWL_F_KMUL 11:0
`define SCWL_F_UPER 15:0
// ==========================================================
// Masks and reset values
`define SCWL_CTRL_WMASK 15'h6F73
`define SCWL_CTRL_RST 15'h0100
`define SCWL_KMUL_RST 12'h0000
`define SCWL_UPER_RST 16'h00FF
`define SCWL_CNT_ZERO 16'h0000
`define SCWL_CNT_ONE 16'h0001
`define SCWL_KEY_FULL 12'hFFF
`define SCWL_KEY_ZERO 12'h000
`define SCWL_KEY_STEP 12'h001
`define SCWL_KEY_RATE 4'hF
`define SCWL_KEY_DIV0 4'h0
`define SCWL_KEY_DIV1 4'h1
`define SCWL_RD_ZERO 32'h0000_0000
`define SCWL_MODE_LAST 3'h4
`endif

// *** scwl_pkg.sv ***
// Purpose: Types shared by the control word block
// Assumes: scwl_defs.svh supplies all numbers
// Notes: Mode order matches the field encoding 0..4
package scwl_pkg;
	typedef enum logic [2:0] {
		SCWL_SINGLE, SCWL_FSK, SCWL_RFSK, SCWL_CHIRP, SCWL_BPSK
	} scwl_mode_t;

	typedef enum logic [1:0] {SW_IDLE, SW_UP, SW_DOWN} scwl_sweep_state_t;

	typedef struct packed {
		logic [14:0] ctrl_buf;
		logic [14:0] ctrl_act;
		logic [11:0] kmul_buf;
		logic [11:0] kmul_act;
		logic [15:0] upd_period;
		logic [15:0] upd_cnt;
		logic [1:0] sync_upd;
		logic [1:0] sync_key;
		logic ext_prev;
		logic shot;
		logic acc1_clr;
		logic acc2_clr;
		logic upd_pulse;
		logic pin_drive;
		logic [11:0] key_factor;
		logic [31:0] rdata;
	} scwl_main_t;

	typedef struct packed {
		logic [11:0] factor;
		logic [3:0] div;
	} scwl_ramp_st_t;

	// Unused codes fall back to single tone
	function automatic scwl_mode_t scwl_mode_dec(input logic [2:0] f);
		scwl_mode_t m;
		m = SCWL_SINGLE;
		case (f)
			3'h1: m = SCWL_FSK;
			3'h2: m = SCWL_RFSK;
			3'h3: m = SCWL_CHIRP;
			3'h4: m = SCWL_BPSK;
			default: m = SCWL_SINGLE;
		endcase
		return m;
	endfunction
endpackage

// *** scwl_sweep.sv ***
// Purpose: Triangular frequency sweep direction control
// Assumes: Frequency datapath flags arrival at each tuning frequency
// Notes: Restarts upward whenever the sweep is re-enabled
`timescale 1ns/100ps
`include "scwl_defs.svh"
module scwl_sweep (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic en_i,
	input wire logic reached_first_tuning_frequency_i,
	input wire logic reached_second_tuning_frequency_i,
	output logic run_o,
	output logic up_o
);
	import scwl_pkg::*;
	scwl_sweep_state_t r, n;

	// ==========================================================
	// Direction turns at each end, no software help needed
	always_comb
	begin
		n = r;
		case (r)
			SW_IDLE: if (en_i) n = SW_UP;
			SW_UP: if (!en_i) n = SW_IDLE;
				else if (reached_second_tuning_frequency_i) n = SW_DOWN;
			SW_DOWN: if (!en_i) n = SW_IDLE;
				else if (reached_first_tuning_frequency_i) n = SW_UP;
			default: n = SW_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			r <= SW_IDLE;
		else
			r <= n;
	end

	assign run_o = (r != SW_IDLE);
	assign up_o = (r == SW_UP);
endmodule // scwl_sweep

// *** scwl_ramp.sv ***
// Purpose: Internal amplitude keying ramp
// Assumes: Key level already synchronised to clk_i
// Notes: One step per rate period; slower ramps trade keying speed for less splatter
`timescale 1ns/100ps
`include "scwl_defs.svh"
module scwl_ramp (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic run_i,
	input wire logic key_on_i,
	output logic [11:0] factor_o
);
	import scwl_pkg::*;
	scwl_ramp_st_t r, n;

	// ==========================================================
	// Ramp toward full scale while keyed on, toward zero when off
	always_comb
	begin
		n = r;
		if (!run_i)
		begin
			n.factor = `SCWL_KEY_ZERO;
			n.div = `SCWL_KEY_DIV0;
		end
		else if (r.div != `SCWL_KEY_RATE)
			n.div = r.div + `SCWL_KEY_DIV1;
		else
		begin
			n.div = `SCWL_KEY_DIV0;
			if (key_on_i && r.factor != `SCWL_KEY_FULL)
				n.factor = r.factor + `SCWL_KEY_STEP;
			else if (!key_on_i && r.factor != `SCWL_KEY_ZERO)
				n.factor = r.factor - `SCWL_KEY_STEP;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			r <= '{factor: `SCWL_KEY_ZERO, div: `SCWL_KEY_DIV0};
		else
			r <= n;
	end

	assign factor_o = r.factor;
endmodule // scwl_ramp

// *** scwl_ctrl.sv ***
// Purpose: Control word (low half) register bank and its decoded controls
// Assumes: Simple strobe register port, read data one cycle after read strobe
// Notes: Control and keying writes land in buffers; active copies change only on an update strobe
`timescale 1ns/100ps
`include "scwl_defs.svh"
module scwl_ctrl (
	input wire logic clk_i,
	input wire logic nrst_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Update strobe pin, two-way
	input wire logic update_strobe_pin_i,
	output logic update_strobe_pin_o,
	output logic update_strobe_pin_oe_o,
	output logic update_o,
	// Phase accumulator control
	output logic acc1_clear_o,
	output logic acc2_clear_o,
	// Sweep control
	input wire logic reached_first_tuning_frequency_i,
	input wire logic reached_second_tuning_frequency_i,
	output logic sweep_run_o,
	output logic sweep_up_o,
	// Mode and output path
	output scwl_pkg::scwl_mode_t mode_o,
	output logic sinc_bypass_o,
	output logic sinc_clk_en_o,
	input wire logic key_pin_i,
	output logic keying_en_o,
	output logic keying_internal_o,
	output logic [11:0] keying_factor_o,
	// Serial port options
	output logic lsb_first_o,
	output logic sdo_en_o
);
	import scwl_pkg::*;

	scwl_main_t r, n;
	logic [11:0] ramp_factor;
	logic sw_run;
	logic sw_up;
	logic int_mode;
	logic upd_evt;
	logic ext_evt;
	logic mode_bad;

	// ==========================================================
	// Sweep direction engine
	// Runs from the active triangle bit; mode choice is software's job
	scwl_sweep u_sweep (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.en_i(r.ctrl_act[`SCWL_B_TRI]),
		.reached_first_tuning_frequency_i(reached_first_tuning_frequency_i),
		.reached_second_tuning_frequency_i(reached_second_tuning_frequency_i),
		.run_o(sw_run),
		.up_o(sw_up)
	);

	// ==========================================================
	// Internal keying ramp
	// Only runs when keying is enabled and sourced internally
	scwl_ramp u_ramp (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.run_i(r.ctrl_act[`SCWL_B_KEYEN] & r.ctrl_act[`SCWL_B_KEYINT]),
		.key_on_i(r.sync_key[1]),
		.factor_o(ramp_factor)
	);

	// ==========================================================
	// Update source selection
	// Internal mode counts down the period; external mode watches the pin
	always_comb
	begin
		int_mode = r.ctrl_act[`SCWL_B_INTUPD];
		ext_evt = !int_mode && r.sync_upd[1] && !r.ext_prev;
		upd_evt = ext_evt || (int_mode && (r.upd_cnt == `SCWL_CNT_ZERO));
		mode_bad = (r.ctrl_act[`SCWL_F_MODE] > `SCWL_MODE_LAST);
	end

	// ==========================================================
	// Next-state logic for the whole bank
	always_comb
	begin
		n = r;
		n.shot = 1'b0;
		n.upd_pulse = 1'b0;
		n.pin_drive = 1'b0;

		// Pin synchronisers; first stage feeds only the second
		n.sync_upd = {r.sync_upd[0], update_strobe_pin_i};
		n.sync_key = {r.sync_key[0], key_pin_i};
		n.ext_prev = r.sync_upd[1];

		// Register writes go to buffers, except the update period and the one-shot, which act directly
		if (wr_i)
		begin
			case (addr_i)
				`SCWL_ADDR_CTRL:
				begin
					// Bit 12 and reserved bits are dropped here
					n.ctrl_buf = wdata_i[`SCWL_F_CTRL] & `SCWL_CTRL_WMASK;
					// Single shot is never stored, so it self-clears
					n.shot = wdata_i[`SCWL_B_ONESHOT];
				end
				`SCWL_ADDR_KMUL:
					n.kmul_buf = wdata_i[`SCWL_F_KMUL];
				`SCWL_ADDR_UPER:
					n.upd_period = wdata_i[`SCWL_F_UPER];
				default:
					n.ctrl_buf = r.ctrl_buf;
			endcase
		end

		// Internal update period counter
		if (!int_mode)
			n.upd_cnt = r.upd_period;
		else if (r.upd_cnt == `SCWL_CNT_ZERO)
			n.upd_cnt = r.upd_period;
		else
			n.upd_cnt = r.upd_cnt - `SCWL_CNT_ONE;

		// Buffer transfer on either update source
		if (upd_evt)
		begin
			n.ctrl_act = r.ctrl_buf;
			n.kmul_act = r.kmul_buf;
			n.upd_pulse = 1'b1;
			n.pin_drive = int_mode;
		end

		// Accumulator clears: level hold plus the one-shot on the first
		n.acc2_clr = n.ctrl_act[`SCWL_B_ACCCLR];
		n.acc1_clr = n.ctrl_act[`SCWL_B_ACCCLR] | n.shot;

		// Keying factor: full scale when keying is off
		if (!n.ctrl_act[`SCWL_B_KEYEN])
			n.key_factor = `SCWL_KEY_FULL;
		else if (n.ctrl_act[`SCWL_B_KEYINT])
			n.key_factor = ramp_factor;
		else
			n.key_factor = n.kmul_act;

		// Read data, valid only in the cycle after the strobe
		n.rdata = `SCWL_RD_ZERO;
		if (rd_i)
		begin
			case (addr_i)
				`SCWL_ADDR_CTRL:
					n.rdata[`SCWL_F_CTRL] = r.ctrl_buf;
				`SCWL_ADDR_KMUL:
					n.rdata[`SCWL_F_KMUL] = r.kmul_buf;
				`SCWL_ADDR_UPER:
					n.rdata[`SCWL_F_UPER] = r.upd_period;
				`SCWL_ADDR_STAT:
					n.rdata = {14'h0000, sw_up, sw_run, mode_bad, r.ctrl_act};
				default:
					n.rdata = `SCWL_RD_ZERO;
			endcase
		end
	end

	// ==========================================================
	// State register
	// Defaults: sinc in path, keying factor full scale, MSB first, serial out off
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			r.ctrl_buf <= `SCWL_CTRL_RST;
			r.ctrl_act <= `SCWL_CTRL_RST;
			r.kmul_buf <= `SCWL_KMUL_RST;
			r.kmul_act <= `SCWL_KMUL_RST;
			r.upd_period <= `SCWL_UPER_RST;
			r.upd_cnt <= `SCWL_UPER_RST;
			r.sync_upd <= 2'h0;
			r.sync_key <= 2'h0;
			r.ext_prev <= 1'b0;
			r.shot <= 1'b0;
			r.acc1_clr <= 1'b0;
			r.acc2_clr <= 1'b0;
			r.upd_pulse <= 1'b0;
			r.pin_drive <= 1'b0;
			r.key_factor <= `SCWL_KEY_FULL;
			r.rdata <= `SCWL_RD_ZERO;
		end
		else
			r <= n;
	end

	// ==========================================================
	// Outputs, all from registers; mode, sweep flags and filter clock enable through decode logic
	assign rdata_o = r.rdata;
	assign update_o = r.upd_pulse;
	// Pin turns around with the active bit; no strobe is driven when input
	assign update_strobe_pin_oe_o = r.ctrl_act[`SCWL_B_INTUPD];
	assign update_strobe_pin_o = r.pin_drive;
	assign acc1_clear_o = r.acc1_clr;
	assign acc2_clear_o = r.acc2_clr;
	assign sweep_run_o = sw_run;
	assign sweep_up_o = sw_up;
	assign mode_o = scwl_mode_dec(r.ctrl_act[`SCWL_F_MODE]);
	assign sinc_bypass_o = r.ctrl_act[`SCWL_B_SINCBYP];
	// Gating the filter clock is the only power saving; bypass loses droop correction
	assign sinc_clk_en_o = !r.ctrl_act[`SCWL_B_SINCBYP];
	assign keying_en_o = r.ctrl_act[`SCWL_B_KEYEN];
	assign keying_internal_o = r.ctrl_act[`SCWL_B_KEYINT];
	assign keying_factor_o = r.key_factor;
	assign lsb_first_o = r.ctrl_act[`SCWL_B_LSB];
	assign sdo_en_o = r.ctrl_act[`SCWL_B_SDO];
endmodule // scwl_ctrl

// *** scwl_ctrl_properties.sv ***
// Purpose: Port-level checks on the control word block
// Assumes: One clock, reset active low
// Notes: Period never set to zero, so update pulses stay one cycle
`timescale 1ns/100ps
`include "scwl_defs.svh"
module scwl_ctrl_properties
	import scwl_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic update_strobe_pin_o,
	input wire logic update_strobe_pin_oe_o,
	input wire logic update_o,
	input wire logic acc1_clear_o,
	input wire logic acc2_clear_o,
	input wire logic reached_second_tuning_frequency_i,
	input wire logic sweep_up_o,
	input scwl_mode_t mode_o,
	input wire logic sinc_bypass_o,
	input wire logic sinc_clk_en_o,
	input wire logic keying_en_o,
	input wire logic [11:0] keying_factor_o
);
	// ==========================================
	// Assertions
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	a_acc_both_clear: assert property (acc2_clear_o |-> acc1_clear_o)
		else $error("acc2 clear without acc1 clear");
	a_one_shot: assert property (
		wr_i && addr_i == `SCWL_ADDR_CTRL && wdata_i[`SCWL_B_ONESHOT] |=> acc1_clear_o)
		else $error("one-shot clear missing");
	a_sweep_turn: assert property (
		sweep_up_o && reached_second_tuning_frequency_i |=> !sweep_up_o)
		else $error("sweep did not turn down");
	// The decoded mode may only move on a buffer transfer
	a_mode_on_update: assert property (!$stable(mode_o) |-> update_o)
		else $error("mode changed without a transfer");
	a_sinc_gate: assert property (sinc_bypass_o != sinc_clk_en_o)
		else $error("filter clock not gated by bypass");
	a_key_off_full: assert property (
		!keying_en_o && $past(!keying_en_o) |-> keying_factor_o == `SCWL_KEY_FULL)
		else $error("factor not full with keying off");
	a_int_pulse: assert property (update_strobe_pin_o |-> update_o)
		else $error("pin pulse without transfer");
	a_ext_quiet: assert property (
		!update_strobe_pin_oe_o && $past(!update_strobe_pin_oe_o) |-> !update_strobe_pin_o)
		else $error("pin driven in external mode");
	a_update_single: assert property (update_o |=> !update_o)
		else $error("update longer than one cycle");
	a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == `SCWL_RD_ZERO)
		else $error("read data outside read slot");
	// Main scenarios reached
	c_update: cover property (update_o);
	c_turn: cover property (sweep_up_o && reached_second_tuning_frequency_i);
	c_shot: cover property (acc1_clear_o && !acc2_clear_o);
endmodule // scwl_ctrl_properties

bind scwl_ctrl scwl_ctrl_properties u_props (.*);

// *** test_synth_control_word_low.sv ***
// Purpose: Self-checking bench for the control word block
// Assumes: 20 MHz clock, register port with one-cycle read latency
// Notes: Waits are bounded; a spent bound ends the run as a mismatch
`timescale 1ns/100ps
module test_synth_control_word_low;
	import scwl_pkg::*;
	logic clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, update_strobe_pin_i = 0;
	logic reached_first_tuning_frequency_i = 0, reached_second_tuning_frequency_i = 0;
	logic key_pin_i = 0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000, rdata_o;
	logic update_strobe_pin_o, update_strobe_pin_oe_o, update_o, acc1_clear_o;
	logic acc2_clear_o, sweep_run_o, sweep_up_o, sinc_bypass_o, sinc_clk_en_o;
	logic keying_en_o, keying_internal_o, lsb_first_o, sdo_en_o;
	logic [11:0] keying_factor_o;
	scwl_mode_t mode_o;
	int failures = 0, samples_checked = 0;
	scwl_ctrl dut (.*);
	// ==========================================
	// Clock and tasks
	always #25 clk_i = ~clk_i;
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1;
		@(posedge clk_i);
		wr_i <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1;
		@(posedge clk_i);
		rd_i <= 0;
		#1 chk(n, e, rdata_o);
	endtask
	// Waits for n transfers; two make sure a fresh buffer is taken
	task upd(input int n);
		int i;
		repeat (n)
		begin
			i = 0;
			@(posedge clk_i);
			#1;
			while (update_o !== 1'b1 && i < 600)
			begin
				@(posedge clk_i);
				#1 i++;
			end
			if (i >= 600)
			begin
				failures++;
				test_done;
			end
		end
		@(posedge clk_i);
		#1;
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Guard against a hang anywhere
	initial
	begin
		#3000000;
		failures++;
		test_done;
	end
	// ==========================================
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk_i);
		nrst_i <= 1;
		rd(8'h00, 32'h0000_0100, "ctrl");
		rd(8'h04, 32'h0000_0000, "kmul");
		chk("oe", 1, update_strobe_pin_oe_o);
		chk("sinc", 0, sinc_bypass_o);
		$display("test reset done");
		// Ignored bit twelve set on purpose, reserved bits kept zero; mode ramped FSK
		wr(8'h00, 32'h0000_F573);
		rd(8'h00, 32'h0000_6573, "ctrl mask");
		upd(2);
		rd(8'h0C, 32'h0003_6573, "status");
		chk("acc1", 1, acc1_clear_o);
		chk("acc2", 1, acc2_clear_o);
		chk("clk en", 0, sinc_clk_en_o);
		chk("lsb", 1, lsb_first_o);
		chk("sdo", 1, sdo_en_o);
		@(posedge clk_i) reached_second_tuning_frequency_i <= 1;
		@(posedge clk_i) reached_second_tuning_frequency_i <= 0;
		#1 chk("down", 0, sweep_up_o);
		@(posedge clk_i) reached_first_tuning_frequency_i <= 1;
		@(posedge clk_i) reached_first_tuning_frequency_i <= 0;
		#1 chk("up", 1, sweep_up_o);
		$display("test fields done");
		for (int m = 0; m < 8; m++)
		begin
			wr(8'h00, 32'h0000_0100 | (m << 9));
			upd(2);
			chk("mode", (m < 5) ? m : 0, mode_o);
			// Status flags an undefined code and shows the active word
			rd(8'h0C, ((m > 4) ? 32'h0000_8000 : 32'h0000_0000) | 32'h0000_0100 | (m << 9),
				"status mode");
		end
		$display("test modes done");
		wr(8'h00, 32'h0000_0000);
		// One transfer only: after it the pin is an input and stays quiet
		upd(1);
		chk("oe ext", 0, update_strobe_pin_oe_o);
		wr(8'h04, 32'h0000_0ABC);
		wr(8'h00, 32'h0000_0020);
		repeat (20) @(posedge clk_i);
		#1 chk("held", 0, keying_en_o);
		@(posedge clk_i) update_strobe_pin_i <= 1;
		upd(1);
		chk("key en", 1, keying_en_o);
		chk("factor", 32'h0000_0ABC, keying_factor_o);
		@(posedge clk_i) update_strobe_pin_i <= 0;
		wr(8'h00, 32'h0000_0030);
		@(posedge clk_i) update_strobe_pin_i <= 1;
		upd(1);
		chk("internal", 1, keying_internal_o);
		chk("ramp", 0, keying_factor_o);
		// Keyed on: one step per 16 cycles, so two steps after 40 cycles
		@(posedge clk_i) update_strobe_pin_i <= 0;
		key_pin_i <= 1;
		repeat (40) @(posedge clk_i);
		#1 chk("ramp up", 2, keying_factor_o);
		wr(8'h00, 32'h0000_8030);
		#1 chk("shot", 1, acc1_clear_o);
		chk("acc2 off", 0, acc2_clear_o);
		@(posedge clk_i);
		#1 chk("shot end", 0, acc1_clear_o);
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0000_0000, "unmapped");
		$display("test update done");
		test_done;
	end
endmodule // test_synth_control_word_low
